// ---- design/adsr_core.sv ----
// serial register-access front end with its register file
// assumes host-driven mode 3 link pins and a 100 MHz clk
`timescale 1ns/1ns
`include "adsr_map.svh"
module adsr_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic scan_step,
  output logic dout_o,
  output logic dout_oe,
  output logic [3:0] gpio_o,
  output logic [2:0] active_ch_o,
  output logic [5:0] ainpos_o,
  output logic [5:0] ainneg_o,
  output logic [2:0] setup_sel_o,
  output logic [15:0] setup_cfg_o,
  output logic [15:0] filt_cfg_o,
  output logic [23:0] offset_o,
  output logic [23:0] gain_o
);
  parameter logic [15:0] ID_VALUE = 16'h5A5A; // arbitrary value
  logic [1:0] rsync_q;
  logic srst_n;
  logic [2:0] sclk_q, cs_q, din_q;
  logic sclk_s, cs_s, din_s, sclk_prev_q;
  logic cs_prev_q, rise, fall;
  adsr_pkg::adsr_state_e state_q;
  logic [4:0] cnt_q;
  logic [23:0] sh_q;
  logic [5:0] addr_q;
  logic [6:0] ones_q;
  logic soft_rst;
  logic [15:0] ch_q [`ADSR_NUM_CHANNELS];
  logic [15:0] setup_q [`ADSR_NUM_SETUPS];
  logic [15:0] filt_q [`ADSR_NUM_SETUPS];
  logic [23:0] offs_q [`ADSR_NUM_SETUPS];
  logic [23:0] gain_q [`ADSR_NUM_SETUPS];
  logic [15:0] gpio_q;
  logic [2:0] scan_q;
  logic [2:0] step_q;
  logic step_prev_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rsync_q <= 2'b00;
    else rsync_q <= {rsync_q[0], 1'b1};
  end
  assign srst_n = rsync_q[1];

  // three-stage pin sync, change taken when stages two and three agree
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      sclk_q <= 3'b111;
      cs_q <= 3'b111;
      din_q <= 3'b111;
      step_q <= 3'b000;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_q <= {cs_q[1:0], cs_n};
      din_q <= {din_q[1:0], din};
      step_q <= {step_q[1:0], scan_step};
    end
  end
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      sclk_s <= 1'b1;
      cs_s <= 1'b1;
      din_s <= 1'b1;
      sclk_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
      step_prev_q <= 1'b0;
    end else begin
      if (sclk_q[2] == sclk_q[1]) sclk_s <= sclk_q[2];
      if (cs_q[2] == cs_q[1]) cs_s <= cs_q[2];
      if (din_q[2] == din_q[1]) din_s <= din_q[2];
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_s;
      if (step_q[2] == step_q[1]) step_prev_q <= step_q[2];
    end
  end
  wire cs_active = !cs_s;
  wire cs_rise = cs_s && !cs_prev_q;
  assign rise = sclk_s && !sclk_prev_q && cs_active;
  assign fall = !sclk_s && sclk_prev_q && cs_active;
  wire step_sync = step_q[2];
  wire step_pulse = step_sync && !step_prev_q && (step_q[2] == step_q[1]);

  // command decode
  wire [7:0] cmd_byte = {sh_q[6:0], din_s};
  wire cmd_ok = !cmd_byte[`ADSR_CMD_WEN_BIT];
  wire cmd_rd = cmd_byte[`ADSR_CMD_RD_BIT];
  wire [5:0] cmd_addr = cmd_byte[5:0];
  wire [2:0] ix = addr_q[2:0];
  wire [5:0] grp = {addr_q[5:3], 3'b000};
  wire [7:0] status_byte = {5'b10000, scan_q};

  // data length per register, 0 means no data phase
  function automatic logic [4:0] len_of(input logic [5:0] a, input logic rd);
    logic [5:0] g;
    g = {a[5:3], 3'b000};
    len_of = 5'd0;
    if (a == `ADSR_ADDR_ID) len_of = rd ? 5'd16 : 5'd0;
    else if (a == `ADSR_ADDR_GPIOCON) len_of = 5'd16;
    else if (a == `ADSR_ADDR_STATUS) len_of = rd ? 5'd8 : 5'd0;
    else if (g == 6'h10 || g == 6'h18)
      len_of = (a[5:0] < 6'h18) ? 5'd16 : 5'd0;
    else if (g == `ADSR_ADDR_SETUP0 || g == `ADSR_ADDR_FILT0) len_of = 5'd16;
    else if (g == `ADSR_ADDR_OFFS0 || g == `ADSR_ADDR_GAIN0) len_of = 5'd24;
  endfunction
  wire [4:0] cmd_len = len_of(cmd_addr, cmd_rd);

  function automatic logic [23:0] rd_val(input logic [5:0] a);
    logic [5:0] g;
    g = {a[5:3], 3'b000};
    rd_val = 24'h000000;
    if (a == `ADSR_ADDR_ID) rd_val = {ID_VALUE, 8'h00};
    else if (a == `ADSR_ADDR_GPIOCON) rd_val = {gpio_q, 8'h00};
    else if (a == `ADSR_ADDR_STATUS) rd_val = {status_byte, 16'h0000};
    else if (g == `ADSR_ADDR_CH0) rd_val = {ch_q[a[2:0]], 8'h00};
    else if (g == `ADSR_ADDR_SETUP0) rd_val = {setup_q[a[2:0]], 8'h00};
    else if (g == `ADSR_ADDR_FILT0) rd_val = {filt_q[a[2:0]], 8'h00};
    else if (g == `ADSR_ADDR_OFFS0) rd_val = offs_q[a[2:0]];
    else if (g == `ADSR_ADDR_GAIN0) rd_val = gain_q[a[2:0]];
  endfunction
  wire [23:0] cmd_rdata = rd_val(cmd_addr);

  // 64 clocks with input high, counted on sample edges
  wire ones_hit = rise && din_s && (ones_q == `ADSR_RESET_ONES - 7'd1);
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) ones_q <= 7'd0;
    else if (cs_rise || (rise && !din_s)) ones_q <= 7'd0;
    else if (ones_hit) ones_q <= 7'd0;
    else if (rise) ones_q <= ones_q + 7'd1;
  end
  assign soft_rst = ones_hit;

  wire last_bit = rise && (cnt_q == 5'd1);
  wire wr_done = (state_q == adsr_pkg::ADSR_WRITE) && last_bit;
  wire [23:0] wdata = {sh_q[22:0], din_s};

  // write strobes per register group
  wire wr_ch = wr_done && (grp == `ADSR_ADDR_CH0);
  wire wr_set = wr_done && (grp == `ADSR_ADDR_SETUP0);
  wire wr_filt = wr_done && (grp == `ADSR_ADDR_FILT0);
  wire wr_offs = wr_done && (grp == `ADSR_ADDR_OFFS0);
  wire wr_gain = wr_done && (grp == `ADSR_ADDR_GAIN0);
  wire wr_gpio = wr_done && (addr_q == `ADSR_ADDR_GPIOCON);

  // first fall of a read keeps the msb already on the pin
  wire [4:0] rd_len = len_of(addr_q, 1'b1);
  wire rd_shift = fall && (cnt_q != rd_len);

  // transaction sequencer
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_q <= adsr_pkg::ADSR_CMD;
      cnt_q <= 5'd8;
      sh_q <= 24'h000000;
      addr_q <= 6'h00;
    end else if (cs_rise || soft_rst) begin
      state_q <= adsr_pkg::ADSR_CMD;
      cnt_q <= 5'd8;
      sh_q <= 24'h000000;
    end else begin
      unique case (state_q)
        adsr_pkg::ADSR_CMD: begin
          if (rise) begin
            sh_q <= {sh_q[22:0], din_s};
            cnt_q <= cnt_q - 5'd1;
            if (cnt_q == 5'd1) begin
              addr_q <= cmd_addr;
              cnt_q <= (cmd_len == 5'd0) ? 5'd8 : cmd_len;
              if (!cmd_ok) state_q <= adsr_pkg::ADSR_CMD;
              else if (cmd_len == 5'd0) state_q <= adsr_pkg::ADSR_CMD;
              else if (cmd_rd) begin
                state_q <= adsr_pkg::ADSR_READ;
                sh_q <= cmd_len == 5'd8 ? {cmd_rdata[23:16], 16'h0000}
                      : cmd_rdata;
              end else state_q <= adsr_pkg::ADSR_WRITE;
              if (!cmd_ok) cnt_q <= 5'd8;
            end
          end
        end
        adsr_pkg::ADSR_WRITE: begin
          if (rise) begin
            sh_q <= wdata;
            cnt_q <= cnt_q - 5'd1;
            if (cnt_q == 5'd1) begin
              state_q <= adsr_pkg::ADSR_CMD;
              cnt_q <= 5'd8;
            end
          end
        end
        adsr_pkg::ADSR_READ: begin
          if (rise) begin
            cnt_q <= cnt_q - 5'd1;
            if (cnt_q == 5'd1) begin
              state_q <= adsr_pkg::ADSR_CMD;
              cnt_q <= 5'd8;
            end
          end
          if (rd_shift) sh_q <= {sh_q[22:0], 1'b0};
        end
        adsr_pkg::ADSR_SKIP: state_q <= adsr_pkg::ADSR_CMD;
      endcase
    end
  end

  // data out driven on falling edge, top bit of the shifter
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      dout_o <= 1'b1;
      dout_oe <= 1'b0;
    end else begin
      dout_oe <= cs_active;
      if (state_q == adsr_pkg::ADSR_READ && !cs_rise)
        dout_o <= sh_q[23];
      else dout_o <= 1'b1;
    end
  end

  // register file: channels, setups, general outputs
  genvar gi;
  generate
    for (gi = 0; gi < `ADSR_NUM_SETUPS; gi = gi + 1) begin : g_set
      wire hit = (ix == 3'(gi));
      always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
          ch_q[gi] <= (gi == 0) ? `ADSR_RST_CH0 : `ADSR_RST_CHN;
          setup_q[gi] <= `ADSR_RST_SETUP;
          filt_q[gi] <= `ADSR_RST_FILT;
          offs_q[gi] <= `ADSR_RST_OFFS;
          gain_q[gi] <= `ADSR_RST_GAIN;
        end else if (soft_rst) begin
          ch_q[gi] <= (gi == 0) ? `ADSR_RST_CH0 : `ADSR_RST_CHN;
          setup_q[gi] <= `ADSR_RST_SETUP;
          filt_q[gi] <= `ADSR_RST_FILT;
          offs_q[gi] <= `ADSR_RST_OFFS;
          gain_q[gi] <= `ADSR_RST_GAIN;
        end else if (hit) begin
          if (wr_ch) ch_q[gi] <= wdata[15:0];
          if (wr_set) setup_q[gi] <= wdata[15:0];
          if (wr_filt) filt_q[gi] <= wdata[15:0];
          if (wr_offs) offs_q[gi] <= wdata;
          if (wr_gain) gain_q[gi] <= wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) gpio_q <= `ADSR_RST_GPIO;
    else if (soft_rst) gpio_q <= `ADSR_RST_GPIO;
    else if (wr_gpio) gpio_q <= wdata[15:0];
  end

  // scan: next enabled channel on each conversion step
  logic [2:0] nxt;
  always_comb begin
    nxt = scan_q;
    for (int k = 7; k >= 1; k--) begin
      if (ch_q[3'(scan_q + 3'(k))][15]) nxt = 3'(scan_q + 3'(k));
    end
  end
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) scan_q <= 3'd0;
    else if (soft_rst) scan_q <= 3'd0;
    else if (step_pulse) scan_q <= nxt;
  end

  // current channel, its input pair and its setup
  wire [15:0] cur_ch = ch_q[scan_q];
  wire [2:0] cur_set = cur_ch[14:12];
  wire [5:0] ainpos_d = {1'b0, cur_ch[9:5]};
  wire [5:0] ainneg_d = {1'b0, cur_ch[4:0]};
  // mux-step mode follows the scan index, else static levels
  wire [3:0] gpio_d = gpio_q[11] ? {1'b0, scan_q} : gpio_q[3:0];

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      gpio_o <= 4'h0;
      active_ch_o <= 3'd0;
      ainpos_o <= 6'h00;
      ainneg_o <= 6'h01;
      setup_sel_o <= 3'd0;
    end else begin
      gpio_o <= gpio_d;
      active_ch_o <= scan_q;
      ainpos_o <= ainpos_d;
      ainneg_o <= ainneg_d;
      setup_sel_o <= cur_set;
    end
  end

  // setup registers of the current channel
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      setup_cfg_o <= `ADSR_RST_SETUP;
      filt_cfg_o <= `ADSR_RST_FILT;
      offset_o <= `ADSR_RST_OFFS;
      gain_o <= `ADSR_RST_GAIN;
    end else begin
      setup_cfg_o <= setup_q[cur_set];
      filt_cfg_o <= filt_q[cur_set];
      offset_o <= offs_q[cur_set];
      gain_o <= gain_q[cur_set];
    end
  end
endmodule

// ---- design/adsr_map.svh ----
// register map, field positions, reset values and counts for the
// serial register-access front end; assumes a 100 MHz core clock
// Summary of operation
// - link is mode 3, clock idles high
// - drive on falling edge, sample rising
// - works with chip select tied low
// - eight-bit write-only command register gates access
// - after reset, expect a command byte
// - command picks direction and six-bit address
// - after data phase, await next command
// - write data 16 or 24 bits
// - read data shifted out on data pin
// - read-only identification register holds part code
// - 64 clocks with input high reset all
// - chip select high aborts, back to idle
// - eight setups, any setup on any channel
// - setup holds buffers, gain, filter, rate, reference
// - channel picks any positive/negative input pair
// - general outputs step external multiplexer with scan
`ifndef ADSR_MAP_SVH
`define ADSR_MAP_SVH
`define ADSR_ADDR_COMMAND 6'h00
`define ADSR_ADDR_STATUS 6'h00
`define ADSR_ADDR_GPIOCON 6'h06
`define ADSR_ADDR_ID 6'h07
`define ADSR_ADDR_CH0 6'h10
`define ADSR_ADDR_SETUP0 6'h20
`define ADSR_ADDR_FILT0 6'h28
`define ADSR_ADDR_OFFS0 6'h30
`define ADSR_ADDR_GAIN0 6'h38
`define ADSR_CMD_WEN_BIT 7
`define ADSR_CMD_RD_BIT 6
`define ADSR_RST_CH0 16'h8001
`define ADSR_RST_CHN 16'h0001
`define ADSR_RST_SETUP 16'h1000
`define ADSR_RST_FILT 16'h0500
`define ADSR_RST_OFFS 24'h800000
`define ADSR_RST_GAIN 24'h500000
`define ADSR_RST_GPIO 16'h0800
`define ADSR_RESET_ONES 7'd64
`define ADSR_NUM_SETUPS 8
`define ADSR_NUM_CHANNELS 8
`endif

// ---- design/adsr_pkg.sv ----
// types shared by the serial register-access front end
// assumes the map header is compiled alongside
package adsr_pkg;
  typedef enum logic [1:0] {
    ADSR_CMD,
    ADSR_WRITE,
    ADSR_READ,
    ADSR_SKIP
  } adsr_state_e;
  typedef logic [23:0] adsr_word_t;
endpackage

// ---- verification/adsr_host.sv ----
// host serial controller model driving the mode 3 link
// assumes the bench calls its tasks just after a clk falling edge
`timescale 1ns/1ns
module adsr_host (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // deselect also releases din to the inverse of its last value
  task automatic select(input logic lvl);
    cs_n = lvl;
    if (lvl) begin
      din = ~din;
    end
    #80;
  endtask
  // n bits, msb first, of tx; rx collects dout at each rise
  task automatic shift(input int n, input logic [23:0] tx,
                       output logic [23:0] rx);
    rx = 24'h000000;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      #80;
      sclk = 1'b1;
      rx = {rx[22:0], dout};
      #80;
    end
  endtask
endmodule

// ---- verification/adsr_chk.sv ----
// port checker for the serial register-access front end
// assumes the host keeps sclk half periods of eight clk cycles
`timescale 1ns/1ns
module adsr_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic scan_step,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic [2:0] active_ch_o,
  input wire logic [15:0] setup_cfg_o,
  input wire logic [23:0] offset_o,
  input wire logic [23:0] gain_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic sclk_q;
  logic [6:0] ones_q;
  logic [3:0] since_q;
  wire rise = sclk & ~sclk_q;
  wire [6:0] ones_inc = (ones_q == 7'h7F) ? ones_q : ones_q + 7'h01;
  wire [6:0] ones_d = cs_n ? 7'h00
                    : (rise ? (din ? ones_inc : 7'h00) : ones_q);
  wire [3:0] since_d = rise ? 4'h0
                     : (since_q == 4'hF ? since_q : since_q + 4'h1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b1;
      ones_q <= 7'h00;
      since_q <= 4'hF;
    end else begin
      sclk_q <= sclk;
      ones_q <= ones_d;
      since_q <= since_d;
    end
  end
  sequence s_64ones;
    (ones_q == 7'h3F) ##1 (ones_q == 7'h40);
  endsequence
  sequence s_released;
    !dout_oe && dout_o;
  endsequence
  property p_reset; s_64ones |-> ##[1:12] (offset_o == 24'h800000 &&
    gain_o == 24'h500000 && setup_cfg_o == 16'h1000); endproperty
  a_reset: assert property (p_reset) else $error("no reset by ones");
  property p_oe_on; $fell(cs_n) |-> ##[1:8] dout_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe not on");
  property p_oe_off; cs_n [*6] |-> !dout_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe stuck");
  property p_abort; $rose(cs_n) |-> ##[1:8] s_released; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_dout_idle; !dout_oe [*3] |-> dout_o; endproperty
  a_dout_idle: assert property (p_dout_idle) else $error("dout low");
  property p_dout_stable; (!cs_n && sclk) [*8] |-> $stable(dout_o); endproperty
  a_dout_stable: assert property (p_dout_stable)
    else $error("dout moved");
  property p_cfg_on_rise;
    ($changed(offset_o) || $changed(gain_o)) |-> since_q <= 4'hA;
  endproperty
  a_cfg_on_rise: assert property (p_cfg_on_rise)
    else $error("odd update");
  property p_ch_hold; (!scan_step) [*8] |-> $stable(active_ch_o); endproperty
  a_ch_hold: assert property (p_ch_hold) else $error("scan moved");
endmodule
bind adsr_core adsr_chk u_chk (.clk(clk), .nrst(nrst), .sclk(sclk),
  .cs_n(cs_n), .din(din), .scan_step(scan_step), .dout_o(dout_o),
  .dout_oe(dout_oe), .active_ch_o(active_ch_o), .setup_cfg_o(setup_cfg_o),
  .offset_o(offset_o), .gain_o(gain_o));

// ---- verification/tb.sv ----
// self-checking bench: register accesses through the host model
// assumes adsr_core, adsr_host and the bound checker are compiled
`timescale 1ns/1ns
module tb;
  localparam logic [15:0] ID = 16'hC3A5; // arbitrary value
  logic clk, nrst, scan_step, sclk, cs_n, din, dout_o, dout_oe;
  logic [3:0] gpio_o;
  logic [2:0] active_ch_o, setup_sel_o;
  logic [5:0] ainpos_o, ainneg_o;
  logic [15:0] setup_cfg_o, filt_cfg_o;
  logic [23:0] offset_o, gain_o, rx;
  int fails = 0;
  int checks = 0;
  adsr_core #(.ID_VALUE(ID)) dut (.clk(clk), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .din(din), .scan_step(scan_step), .dout_o(dout_o),
    .dout_oe(dout_oe), .gpio_o(gpio_o), .active_ch_o(active_ch_o),
    .ainpos_o(ainpos_o), .ainneg_o(ainneg_o), .setup_sel_o(setup_sel_o),
    .setup_cfg_o(setup_cfg_o), .filt_cfg_o(filt_cfg_o),
    .offset_o(offset_o), .gain_o(gain_o));
  adsr_host h (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_o));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // command byte, then n data bits
  task automatic access(input logic [7:0] cmd, input int n,
                        input logic [23:0] wd);
    h.shift(8, {16'h0000, cmd}, rx);
    h.shift(n, wd, rx);
  endtask
  task automatic ones;
    repeat (4) h.shift(16, 24'h00FFFF, rx);
  endtask
  // one conversion step pulse, then settle
  task automatic step;
    scan_step = 1'b1;
    repeat (6) @(negedge clk);
    scan_step = 1'b0;
    repeat (12) @(negedge clk);
  endtask
  initial begin
    nrst = 1'b0;
    scan_step = 1'b0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    check("rst chan", active_ch_o, 24'h000000);
    check("rst sel", setup_sel_o, 24'h000000);
    check("rst pos", ainpos_o, 24'h000000);
    check("rst neg", ainneg_o, 24'h000001);
    check("rst setup", setup_cfg_o, 24'h001000);
    check("rst filt", filt_cfg_o, 24'h000500);
    check("rst gain", gain_o, 24'h500000);
    check("rst gpio", gpio_o, 24'h000000);
    h.select(1'b0);
    ones();
    access(8'h47, 16, 24'h000000);
    check("id", rx, {8'h00, ID});
    check("oe", dout_oe, 24'h000001);
    h.shift(8, 24'h0000C7, rx);
    access(8'h47, 16, 24'h000000);
    check("id after bad cmd", rx, {8'h00, ID});
    access(8'h30, 24, 24'hA5C3F0);
    repeat (20) @(negedge clk);
    check("offset", offset_o, 24'hA5C3F0);
    access(8'h70, 24, 24'h000000);
    check("offset read", rx, 24'hA5C3F0);
    access(8'h78, 24, 24'h000000);
    check("gain read", rx, 24'h500000);
    access(8'h40, 8, 24'h000000);
    check("status", rx, 24'h000080);
    h.shift(8, 24'h000038, rx);
    h.shift(12, 24'h000FFF, rx);
    h.select(1'b1);
    check("oe off", dout_oe, 24'h000000);
    h.select(1'b0);
    access(8'h78, 24, 24'h000000);
    check("gain kept", rx, 24'h500000);
    ones();
    repeat (20) @(negedge clk);
    check("offset reset", offset_o, 24'h800000);
    access(8'h11, 16, 24'h00A064);
    access(8'h22, 16, 24'h001234);
    access(8'h06, 16, 24'h000005);
    repeat (20) @(negedge clk);
    check("gpio static", gpio_o, 24'h000005);
    access(8'h06, 16, 24'h000800);
    step();
    check("scan chan", active_ch_o, 24'h000001);
    check("scan pos", ainpos_o, 24'h000003);
    check("scan neg", ainneg_o, 24'h000004);
    check("scan sel", setup_sel_o, 24'h000002);
    check("scan setup", setup_cfg_o, 24'h001234);
    check("mux step", gpio_o, 24'h000001);
    step();
    check("scan wrap", active_ch_o, 24'h000000);
    check("wrap setup", setup_cfg_o, 24'h001000);
    access(8'h47, 16, 24'h000000);
    check("id after reset", rx, {8'h00, ID});
    h.select(1'b1);
    complete_run();
  end
  initial begin
    #300000;
    fails++;
    complete_run();
  end
endmodule
